// ===== bench/lams_monitor.sv
// Port checker for the listen sequencer
`timescale 1ns/10ps
module lams_monitor
(
  // Clock, reset, bus
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  // Radio side
  input wire logic [2:0]  radio_mode_o,
  input wire logic        rx_enable_o,
  input wire logic        buffer_clear_o,
  input wire logic        rx_timeout_o,
  input wire logic        demod_bit_i,
  input wire logic        serial_data_pin_o,
  input wire logic        serial_data_pin_i,
  input wire logic        serial_data_pin_oe_o,
  input wire logic        frame_bit_i,
  input wire logic        mod_bit_o,
  input wire logic        frame_engine_on_o
);
  // ==========
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  bus_ready_a: assert property (psel_i && penable_i |-> pready_o)
    else $error("access phase without ready");
  bad_addr_a: assert property (psel_i && penable_i &&
    paddr_i[1:0] == 2'h0 |-> pslverr_o == (paddr_i > 8'h20))
    else $error("error response wrong");
  listen_go_a: assert property (psel_i && penable_i && pwrite_i &&
    paddr_i == 8'h00 && pwdata_i[6:5] == 2'h2 && radio_mode_o == 3'h1
    |-> ##[1:3] radio_mode_o == 3'h0)
    else $error("listen did not start idle");
  rx_power_a: assert property (rx_enable_o == (radio_mode_o == 3'h4))
    else $error("receiver enable mismatch");
  mode_code_a: assert property (radio_mode_o <= 3'h4)
    else $error("illegal mode code");
  clear_pulse_a: assert property (buffer_clear_o |=> !buffer_clear_o)
    else $error("buffer clear too long");
  timeout_pulse_a: assert property (rx_timeout_o |=> !rx_timeout_o)
    else $error("timeout pulse too long");
  data_delay_a: assert property ($past(reset_n_i) |->
    serial_data_pin_o == $past(demod_bit_i))
    else $error("serial data not one clock late");
  pin_drive_a: assert property (serial_data_pin_oe_o ==
    (!frame_engine_on_o && $past(radio_mode_o) == 3'h4))
    else $error("data pin enable wrong");
  mod_source_a: assert property ($past(reset_n_i) |->
    mod_bit_o == (frame_engine_on_o ? $past(frame_bit_i)
    : $past(serial_data_pin_i)))
    else $error("modulator bit from wrong source");
endmodule

bind lams_sequencer lams_monitor lams_monitor_i (.clk_i, .reset_n_i,
  .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
  .pslverr_o, .radio_mode_o, .rx_enable_o, .buffer_clear_o,
  .rx_timeout_o, .demod_bit_i, .serial_data_pin_o, .serial_data_pin_i,
  .serial_data_pin_oe_o, .frame_bit_i, .mod_bit_o, .frame_engine_on_o);

// ===== bench/lams_radio_model.sv
// Packet handler stand-in raising level and payload flags while receiving, event flags on request
`timescale 1ns/10ps
module lams_radio_model
  import lams_pkg::*;
(
  // Clock and radio state
  input  wire logic       clk_i,
  input  wire logic [2:0] radio_mode_i,
  // Scenario controls
  input  wire logic       level_en_i,
  input  wire logic       payload_en_i,
  input  wire logic [1:0] evt_i,
  // Flags to the sequencer
  output lams_flags_t     flags_o
);
  // ==========
  // Receive time since wakeup
  logic [3:0] rx_cnt = 4'h0;
  always_ff @(posedge clk_i)
    rx_cnt <= (radio_mode_i != 3'h4) ? 4'h0 :
              (rx_cnt == 4'hF) ? rx_cnt : rx_cnt + 4'h1;
  // Signal settles two clocks into the window, payload later
  always_comb
  begin
    flags_o = '0;
    flags_o.signal_level_threshold = level_en_i && rx_cnt >= 4'h2;
    flags_o.pattern_match_flag = flags_o.signal_level_threshold;
    flags_o.payload_complete_flag = payload_en_i && rx_cnt >= 4'h8;
    flags_o.buffer_level_flag = evt_i[0];
    flags_o.frame_sent_flag = evt_i[1];
  end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the listen sequencer
`timescale 1ns/10ps
module tb_top
  import lams_pkg::*;
;
  // ==========
  // Signals
  logic        clk_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  lams_flags_t flags_i;
  logic [2:0]  radio_mode_o;
  logic        rx_enable_o;
  logic        buffer_clear_o;
  logic        rx_timeout_o;
  logic        demod_bit_i = 1'b0;
  logic        frame_bit_i = 1'b0;
  wire logic   serial_data_pin_i;
  logic        serial_data_pin_o;
  logic        serial_data_pin_oe_o;
  logic        rc_osc_on_o;
  logic        mod_bit_o;
  logic        frame_engine_on_o;
  logic [8:0]  payload_limit_o;
  logic [1:0]  evt = 2'h0;
  logic        pin_drv = 1'b0;
  logic        level_en = 1'b0;
  logic        pay_en = 1'b0;
  int          fails = 0;
  int          checks = 0;
  int          seed = 82951;
  int          n;
  logic        err;
  logic [31:0] rdat;
  logic [31:0] v;
  logic [7:0]  ic;
  logic [7:0]  rc;
  localparam int TICK = 4;
  localparam int BIT = 2;

  lams_sequencer #(.TICK_CYCLES(TICK), .CAL_CYCLES(8), .BIT_CYCLES(BIT))
    lams_sequencer_i (.clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .flags_i,
    .radio_mode_o, .rx_enable_o, .rc_osc_on_o, .buffer_clear_o,
    .rx_timeout_o, .demod_bit_i, .frame_bit_i, .mod_bit_o,
    .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe_o,
    .frame_engine_on_o, .payload_limit_o);
  lams_radio_model lams_radio_model_i (.clk_i, .radio_mode_i(radio_mode_o),
    .level_en_i(level_en), .payload_en_i(pay_en), .evt_i(evt),
    .flags_o(flags_i));
  // Whoever enables drives the shared data line
  assign serial_data_pin_i = serial_data_pin_oe_o ? serial_data_pin_o : pin_drv;

  initial
    forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    demod_bit_i <= 1'($random(seed));
    frame_bit_i <= 1'($random(seed));
    pin_drv     <= 1'($random(seed));
  end

  // ==========
  // Helpers
  function automatic int dur(input logic [1:0] b, input logic [7:0] c);
    dur = c * (b == 2'h3 ? 4096 : b == 2'h2 ? 64 : 1) * TICK;
  endfunction
  // Payload ceiling from packet bits: aes first, then unlimited
  function automatic logic [8:0] plim(input logic [2:0] p);
    plim = p[1] ? 9'h042 : (p[2] ? 9'h000 : 9'h0FF);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1)
      @(posedge clk_i);
    r = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Clocks until the radio mode reads m
  task automatic span(input logic [2:0] m, output int k);
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (radio_mode_o !== m && k < 3000);
    if (radio_mode_o !== m)
      fails++;
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========
  // Scenarios
  initial
  begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    apb(1'b0, 8'h00, 32'h0, rdat);
    chk(rdat, 32'h1);
    apb(1'b0, 8'h10, 32'h0, rdat);
    chk(rdat[6], 1'b1);
    apb(1'b1, 8'h10, 32'h80, rdat);
    apb(1'b0, 8'h10, 32'h0, rdat);
    chk(rdat[5], 1'b1);
    repeat (12) @(posedge clk_i);
    apb(1'b0, 8'h10, 32'h0, rdat);
    chk(rdat[6:5], 2'h2);
    chk(rc_osc_on_o, 1'b0);
    apb(1'b0, 8'h24, 32'h0, rdat);
    chk(err, 1'b1);
    chk(rdat, 32'h0);
    repeat (4)
    begin
      v = $random(seed);
      apb(1'b1, 8'h0C, v, rdat);
      apb(1'b0, 8'h0C, 32'h0, rdat);
      chk(rdat, {24'h0, v[7:0]});
    end
    ic = {6'h0, 2'($random(seed))} + 8'h1;
    rc = {5'h0, 3'($random(seed))} + 8'h2;
    apb(1'b1, 8'h08, {24'h0, ic}, rdat);
    apb(1'b1, 8'h0C, {24'h0, rc}, rdat);
    apb(1'b1, 8'h04, 32'h90, rdat);
    apb(1'b1, 8'h00, 32'h41, rdat);
    span(3'h0, n);
    chk(rc_osc_on_o, 1'b1);
    chk(rx_enable_o, 1'b0);
    span(3'h4, n);
    chk(n, dur(2'h2, ic));
    span(3'h0, n);
    chk(n, dur(2'h1, rc));
    level_en <= 1'b1;
    span(3'h4, n);
    repeat (dur(2'h1, rc) + 4) @(posedge clk_i);
    chk(radio_mode_o, 3'h4);
    apb(1'b1, 8'h00, 32'h22, rdat);
    apb(1'b1, 8'h00, 32'h02, rdat);
    repeat (2) @(posedge clk_i);
    chk(radio_mode_o, 3'h2);
    pay_en <= 1'b1;
    apb(1'b1, 8'h00, 32'h01, rdat);
    apb(1'b1, 8'h04, 32'h5A, rdat);
    apb(1'b1, 8'h00, 32'h41, rdat);
    span(3'h4, n);
    span(3'h1, n);
    chk(radio_mode_o, 3'h1);
    apb(1'b1, 8'h00, 32'h01, rdat);
    // End action 10: buffer dropped at the wakeup after a resume only
    apb(1'b1, 8'h04, 32'h54, rdat);
    apb(1'b1, 8'h00, 32'h41, rdat);
    span(3'h4, n);
    chk(buffer_clear_o, 1'b0);
    span(3'h0, n);
    span(3'h4, n);
    chk(buffer_clear_o, 1'b1);
    apb(1'b1, 8'h00, 32'h01, rdat);
    for (int i = 7; i >= 0; i--)
    begin
      apb(1'b1, 8'h20, i, rdat);
      repeat (2) @(posedge clk_i);
      chk(payload_limit_o, plim(3'(i)));
      chk(frame_engine_on_o, i[0]);
    end
    // Continuous receive with no signal: start-count timeout
    level_en <= 1'b0;
    ic = {6'h0, 2'($random(seed))} + 8'h1;
    apb(1'b1, 8'h18, {24'h0, ic}, rdat);
    apb(1'b1, 8'h00, 32'h04, rdat);
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rx_timeout_o !== 1'b1 && n < 3000);
    chk(n, 16 * BIT * ic + 2);
    chk(serial_data_pin_oe_o, 1'b1);
    // Auto transmit: buffer level enters, frame sent leaves
    apb(1'b1, 8'h00, 32'h00, rdat);
    apb(1'b1, 8'h14, 32'h328, rdat);
    evt <= 2'h1;
    repeat (3) @(posedge clk_i);
    chk(radio_mode_o, 3'h3);
    apb(1'b1, 8'h00, 32'h01, rdat);
    chk(radio_mode_o, 3'h3);
    evt <= 2'h3;
    repeat (3) @(posedge clk_i);
    chk(radio_mode_o, 3'h1);
    end_sim;
  end

  initial
  begin
    #300000;
    fails++;
    end_sim;
  end
endmodule

// ===== hw/lams_sequencer.sv
// Listen duty-cycle, auto-mode and data-mode sequencer with APB registers
// ==========================================================
`timescale 1ns/10ps
`include "lams_params.svh"

module lams_sequencer
  import lams_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `LAMS_TICK_US * 1000 / `LAMS_CLK_NS,
  parameter int unsigned CAL_CYCLES  = `LAMS_CAL_CYCLES,
  parameter int unsigned BIT_CYCLES  = `LAMS_BIT_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Packet handler flags
  input  wire lams_flags_t flags_i,
  // Radio control
  output logic [2:0]       radio_mode_o,
  output logic             rx_enable_o,
  output logic             rc_osc_on_o,
  output logic             buffer_clear_o,
  output logic             rx_timeout_o,
  // Data path
  input  wire logic        demod_bit_i,
  input  wire logic        frame_bit_i,
  output logic             mod_bit_o,
  input  wire logic        serial_data_pin_i,
  output logic             serial_data_pin_o,
  output logic             serial_data_pin_oe_o,
  output logic             frame_engine_on_o,
  output logic [8:0]       payload_limit_o
);

  // ==========================================================
  // Helpers
  function automatic logic addr_known(input logic [7:0] a);
    if (a == `LAMS_OPMODE_ADDR) return 1'b1;
    else if (a == `LAMS_CFG1_ADDR) return 1'b1;
    else if (a == `LAMS_IDLE_ADDR) return 1'b1;
    else if (a == `LAMS_RXWIN_ADDR) return 1'b1;
    else if (a == `LAMS_OSC_ADDR) return 1'b1;
    else if (a == `LAMS_AUTO_ADDR) return 1'b1;
    else if (a == `LAMS_TIMEOUT_ADDR) return 1'b1;
    else if (a == `LAMS_STATUS_ADDR) return 1'b1;
    else if (a == `LAMS_PKT_ADDR) return 1'b1;
    else return 1'b0;
  endfunction

  // Phase length in 64 us ticks; coefficient 0 acts as 1
  function automatic logic [20:0] phase_units(input logic [1:0] base,
                                              input logic [7:0] coef);
    logic [20:0] mult;
    logic [20:0] c;
    mult = 21'h000001;
    c    = {13'h0000, coef};
    if (coef == 8'h00)
      c = 21'h000001;
    case (base)
      2'h2:    mult = `LAMS_MID_MULT;
      2'h3:    mult = `LAMS_LONG_MULT;
      default: mult = 21'h000001;
    endcase
    return 21'(mult * c);
  endfunction

  function automatic logic cond_hit(input logic [2:0]  sel,
                                    input lams_flags_t rise,
                                    input logic        ne_fall);
    case (sel)
      3'h1:    return rise.buffer_level_flag;
      3'h2:    return rise.frame_sent_flag;
      3'h3:    return rise.checksum_good_flag;
      3'h4:    return ne_fall;
      3'h5:    return rise.payload_complete_flag;
      3'h6:    return rise.signal_level_threshold;
      3'h7:    return rise.pattern_match_flag;
      default: return 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Registers
  logic [2:0]  mode_bits;
  logic        listen_en;
  logic        abort;
  logic [1:0]  idle_base;
  logic [1:0]  rx_base;
  logic        criteria;
  lams_end_t   end_action;
  logic [7:0]  idle_coef;
  logic [7:0]  rx_coef;
  logic [2:0]  enter_sel;
  logic [2:0]  exit_sel;
  logic [2:0]  transit_mode;
  logic [7:0]  to_start;
  logic [7:0]  to_level;
  logic        pkt_mode;
  logic        pkt_aes;
  logic        pkt_unlim;

  logic        wr;
  logic        rd_setup;
  assign wr       = psel_i && penable_i && pwrite_i && addr_known(paddr_i);
  assign rd_setup = psel_i && !penable_i;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      mode_bits    <= `LAMS_MODE_RESET;
      listen_en    <= 1'b0;
      abort        <= 1'b0;
      idle_base    <= `LAMS_BASE_RESET;
      rx_base      <= `LAMS_BASE_RESET;
      criteria     <= 1'b0;
      end_action   <= END_STAY;
      idle_coef    <= `LAMS_COEF_RESET;
      rx_coef      <= `LAMS_COEF_RESET;
      enter_sel    <= 3'h0;
      exit_sel     <= 3'h0;
      transit_mode <= 3'h0;
      to_start     <= 8'h00;
      to_level     <= 8'h00;
      pkt_mode     <= 1'b1;
      pkt_aes      <= 1'b0;
      pkt_unlim    <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr_i == `LAMS_OPMODE_ADDR)
      begin
        mode_bits <= pwdata_i[2:0];
        listen_en <= pwdata_i[`LAMS_OP_LISTEN];
        abort     <= pwdata_i[`LAMS_OP_ABORT];
      end
      else if (paddr_i == `LAMS_CFG1_ADDR)
      begin
        idle_base  <= pwdata_i[7:6];
        rx_base    <= pwdata_i[5:4];
        criteria   <= pwdata_i[`LAMS_CFG_CRIT];
        end_action <= lams_end_t'(pwdata_i[2:1]);
      end
      else if (paddr_i == `LAMS_IDLE_ADDR)
        idle_coef <= pwdata_i[7:0];
      else if (paddr_i == `LAMS_RXWIN_ADDR)
        rx_coef <= pwdata_i[7:0];
      else if (paddr_i == `LAMS_AUTO_ADDR)
      begin
        enter_sel    <= pwdata_i[7:5];
        exit_sel     <= pwdata_i[4:2];
        transit_mode <= pwdata_i[10:8];
      end
      else if (paddr_i == `LAMS_TIMEOUT_ADDR)
      begin
        to_start <= pwdata_i[7:0];
        to_level <= pwdata_i[15:8];
      end
      else if (paddr_i == `LAMS_PKT_ADDR)
      begin
        pkt_mode  <= pwdata_i[`LAMS_PKT_MODE];
        pkt_aes   <= pwdata_i[`LAMS_PKT_AES];
        pkt_unlim <= pwdata_i[`LAMS_PKT_UNLIM];
      end
    end
  end

  // ==========================================================
  // RC oscillator calibration
  logic        cal_busy;
  logic        cal_done;
  logic [15:0] cal_cnt;
  logic        cal_end;
  logic        cal_req;
  assign cal_end = cal_busy && (cal_cnt == 16'(CAL_CYCLES - 1));
  assign cal_req = wr && (paddr_i == `LAMS_OSC_ADDR)
                   && pwdata_i[`LAMS_OSC_START];

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      cal_busy <= 1'b1;
      cal_done <= 1'b0;
      cal_cnt  <= 16'h0000;
    end
    else if (cal_end)
    begin
      // Completion wins over a start landing in the same cycle
      cal_busy <= 1'b0;
      cal_done <= 1'b1;
      cal_cnt  <= 16'h0000;
    end
    else if (cal_req)
    begin
      cal_busy <= 1'b1;
      cal_done <= 1'b0;
      cal_cnt  <= 16'h0000;
    end
    else if (cal_busy)
      cal_cnt <= cal_cnt + 16'h0001;
  end

  // ==========================================================
  // Duty-cycle state machine
  lams_state_t state;
  lams_state_t next_state;
  logic [2:0]  next_mode;
  logic        next_stop_rx;
  logic        stop_rx;
  logic        discard_pend;
  logic        level_seen;
  logic        phase_done;
  logic        accept;
  logic        timeout_hit;

  assign accept = level_seen
                  && (!criteria || flags_i.pattern_match_flag);

  always_comb
  begin
    next_state   = state;
    next_stop_rx = stop_rx;
    if (!listen_en || abort)
      next_state = ST_MANUAL;
    else
    begin
      case (state)
        ST_MANUAL:
          if (radio_mode_o == MODE_STDBY)
            next_state = ST_IDLE;
        ST_IDLE:
          if (phase_done)
            next_state = ST_WINDOW;
        ST_WINDOW:
          if (accept && end_action == END_STAY)
          begin
            next_state   = ST_STOP;
            next_stop_rx = 1'b1;
          end
          else if (accept)
            next_state = ST_HOLD;
          else if (phase_done)
            next_state = ST_IDLE;
        ST_HOLD:
          if (flags_i.payload_complete_flag || timeout_hit)
          begin
            if (end_action == END_MODE)
            begin
              next_state   = ST_STOP;
              next_stop_rx = 1'b0;
            end
            else
              next_state = ST_IDLE;
          end
        default:
          next_state = ST_STOP;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state   <= ST_MANUAL;
      stop_rx <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      stop_rx <= next_stop_rx;
    end
  end

  // Buffer is dropped at the wake-up that follows a resumed cycle
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      discard_pend   <= 1'b0;
      buffer_clear_o <= 1'b0;
    end
    else
    begin
      buffer_clear_o <= discard_pend && state == ST_IDLE
                        && next_state == ST_WINDOW;
      if (state == ST_HOLD && next_state == ST_IDLE)
        discard_pend <= 1'b1;
      else if (next_state == ST_MANUAL || buffer_clear_o)
        discard_pend <= 1'b0;
    end
  end

  // ==========================================================
  // Phase timer; restarts on every state change
  logic [15:0] tick_cnt;
  logic        tick;
  logic [20:0] phase_cnt;
  logic [20:0] phase_len;
  assign tick      = tick_cnt == 16'(TICK_CYCLES - 1);
  // Window timing starts at receiver turn-on, so wake-up is inside it
  assign phase_len = (state == ST_WINDOW) ? phase_units(rx_base, rx_coef)
                     : phase_units(idle_base, idle_coef);
  assign phase_done = tick && (phase_cnt + 21'h000001 >= phase_len);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || next_state != state || cal_busy)
    begin
      // Timing waits for the RC calibration to settle
      tick_cnt  <= 16'h0000;
      phase_cnt <= 21'h000000;
    end
    else if (tick)
    begin
      tick_cnt  <= 16'h0000;
      phase_cnt <= phase_cnt + 21'h000001;
    end
    else
      tick_cnt <= tick_cnt + 16'h0001;
  end

  // ==========================================================
  // Auto-mode sequencing
  lams_flags_t flags_prev;
  lams_flags_t flags_rise;
  logic        ne_fall;
  logic        auto_on;
  logic        in_transit;
  assign flags_rise = flags_i & ~flags_prev;
  assign ne_fall    = flags_prev.buffer_nonempty_flag
                      && !flags_i.buffer_nonempty_flag;
  // One-sided configuration is treated as disabled
  assign auto_on    = (enter_sel != 3'h0) && (exit_sel != 3'h0);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      flags_prev <= '0;
      in_transit <= 1'b0;
    end
    else
    begin
      flags_prev <= flags_i;
      if (!auto_on || state != ST_MANUAL)
        in_transit <= 1'b0;
      else if (!in_transit && cond_hit(enter_sel, flags_rise, ne_fall))
        in_transit <= 1'b1;
      else if (in_transit && cond_hit(exit_sel, flags_rise, ne_fall))
        in_transit <= 1'b0;
    end
  end

  // ==========================================================
  // Effective radio mode
  always_comb
  begin
    case (next_state)
      ST_IDLE:   next_mode = MODE_SLEEP;
      ST_WINDOW: next_mode = MODE_RX;
      ST_HOLD:   next_mode = MODE_RX;
      ST_STOP:   next_mode = next_stop_rx ? MODE_RX : mode_bits;
      default:   next_mode = in_transit ? transit_mode : mode_bits;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      radio_mode_o <= `LAMS_MODE_RESET;
      rx_enable_o  <= 1'b0;
      rc_osc_on_o  <= 1'b1;
    end
    else
    begin
      radio_mode_o <= next_mode;
      rx_enable_o  <= next_mode == MODE_RX;
      rc_osc_on_o  <= cal_busy || next_state != ST_MANUAL;
    end
  end

  // ==========================================================
  // Receive timeout in units of 16 bit periods
  logic [15:0] bit_pre;
  logic [11:0] bit_cnt;
  logic [11:0] to_len;
  logic        in_rx;
  assign in_rx  = radio_mode_o == MODE_RX;
  assign to_len = level_seen ? {to_level, `LAMS_TO_SHIFT}
                  : {to_start, `LAMS_TO_SHIFT};
  assign timeout_hit = rx_timeout_o;

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i || !in_rx)
    begin
      level_seen   <= 1'b0;
      bit_pre      <= 16'h0000;
      bit_cnt      <= 12'h000;
      rx_timeout_o <= 1'b0;
    end
    else
    begin
      rx_timeout_o <= 1'b0;
      if (flags_i.signal_level_threshold && !level_seen)
      begin
        // Level rise restarts the count with the second figure
        level_seen <= 1'b1;
        bit_pre    <= 16'h0000;
        bit_cnt    <= 12'h000;
      end
      else if (bit_pre == 16'(BIT_CYCLES - 1))
      begin
        bit_pre <= 16'h0000;
        if (to_len != 12'h000 && bit_cnt + 12'h001 == to_len)
          rx_timeout_o <= 1'b1;
        if (bit_cnt != 12'hFFF)
          bit_cnt <= bit_cnt + 12'h001;
      end
      else
        bit_pre <= bit_pre + 16'h0001;
    end
  end

  // ==========================================================
  // Data operation modes
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      mod_bit_o            <= 1'b0;
      serial_data_pin_o    <= 1'b0;
      serial_data_pin_oe_o <= 1'b0;
      frame_engine_on_o    <= 1'b0;
      payload_limit_o      <= `LAMS_FIFO_BYTES;
    end
    else
    begin
      // One register stage only; no byte buffering in continuous mode
      mod_bit_o            <= pkt_mode ? frame_bit_i
                              : serial_data_pin_i;
      serial_data_pin_o    <= demod_bit_i;
      serial_data_pin_oe_o <= !pkt_mode && in_rx;
      frame_engine_on_o    <= pkt_mode;
      if (pkt_unlim && !pkt_aes)
        payload_limit_o <= 9'h000;
      else if (pkt_aes)
        payload_limit_o <= `LAMS_FIFO_BYTES;
      else
        payload_limit_o <= `LAMS_LEN_BYTES;
    end
  end

  // ==========================================================
  // APB read path; data latched in the setup cycle
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_known(paddr_i);

  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
      prdata_o <= 32'h00000000;
    else if (rd_setup)
    begin
      prdata_o <= 32'h00000000;
      if (paddr_i == `LAMS_OPMODE_ADDR)
        prdata_o[7:0] <= {1'b0, listen_en, abort, 2'h0, mode_bits};
      else if (paddr_i == `LAMS_CFG1_ADDR)
        prdata_o[7:0] <= {idle_base, rx_base, criteria, end_action, 1'b0};
      else if (paddr_i == `LAMS_IDLE_ADDR)
        prdata_o[7:0] <= idle_coef;
      else if (paddr_i == `LAMS_RXWIN_ADDR)
        prdata_o[7:0] <= rx_coef;
      else if (paddr_i == `LAMS_OSC_ADDR)
        prdata_o[7:0] <= {1'b0, cal_done, cal_busy, 5'h00};
      else if (paddr_i == `LAMS_AUTO_ADDR)
        prdata_o[10:0] <= {transit_mode, enter_sel, exit_sel, 2'h0};
      else if (paddr_i == `LAMS_TIMEOUT_ADDR)
        prdata_o[15:0] <= {to_level, to_start};
      else if (paddr_i == `LAMS_STATUS_ADDR)
        prdata_o[9:0] <= {stop_rx, in_transit, state, radio_mode_o};
      else if (paddr_i == `LAMS_PKT_ADDR)
        prdata_o[2:0] <= {pkt_unlim, pkt_aes, pkt_mode};
    end
  end

endmodule

// ===== include/lams_params.svh
// Register map, field positions, reset values and timing for the sequencer
`ifndef LAMS_PARAMS_SVH
`define LAMS_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses, one word each)
`define LAMS_OPMODE_ADDR   8'h00
`define LAMS_CFG1_ADDR     8'h04
`define LAMS_IDLE_ADDR     8'h08
`define LAMS_RXWIN_ADDR    8'h0C
`define LAMS_OSC_ADDR      8'h10
`define LAMS_AUTO_ADDR     8'h14
`define LAMS_TIMEOUT_ADDR  8'h18
`define LAMS_STATUS_ADDR   8'h1C
`define LAMS_PKT_ADDR      8'h20

// ==========================================================
// Field positions
`define LAMS_OP_LISTEN     6
`define LAMS_OP_ABORT      5
`define LAMS_CFG_CRIT      3
`define LAMS_OSC_START     7
`define LAMS_OSC_DONE      6
`define LAMS_OSC_BUSY      5
`define LAMS_PKT_MODE      0
`define LAMS_PKT_AES       1
`define LAMS_PKT_UNLIM     2

// ==========================================================
// Reset values
`define LAMS_MODE_RESET    3'h1
`define LAMS_COEF_RESET    8'h01
`define LAMS_BASE_RESET    2'h1

// ==========================================================
// Timing
`define LAMS_CLK_NS        5
`define LAMS_TICK_US       64
`define LAMS_MID_MULT      21'h000040
`define LAMS_LONG_MULT     21'h001000
`define LAMS_CAL_CYCLES    1024
`define LAMS_BIT_CYCLES    100
`define LAMS_TO_SHIFT      4'h0
`define LAMS_FIFO_BYTES    9'h042
`define LAMS_LEN_BYTES     9'h0FF

`endif

// ===== include/lams_pkg.sv
// Types shared by the listen and auto-mode sequencer
package lams_pkg;

  // ==========================================================
  // Radio operating modes
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_STDBY = 3'h1,
    MODE_SYNTH = 3'h2,
    MODE_TX    = 3'h3,
    MODE_RX    = 3'h4
  } lams_mode_t;

  // ==========================================================
  // Duty-cycle states, one-hot
  typedef enum logic [4:0] {
    ST_MANUAL = 5'h01,
    ST_IDLE   = 5'h02,
    ST_WINDOW = 5'h04,
    ST_HOLD   = 5'h08,
    ST_STOP   = 5'h10
  } lams_state_t;

  // ==========================================================
  // End-of-cycle actions
  typedef enum logic [1:0] {
    END_STAY   = 2'h0,
    END_MODE   = 2'h1,
    END_RESUME = 2'h2,
    END_RSVD   = 2'h3
  } lams_end_t;

  // ==========================================================
  // Packet handler flags
  typedef struct packed {
    logic signal_level_threshold;
    logic pattern_match_flag;
    logic payload_complete_flag;
    logic buffer_level_flag;
    logic frame_sent_flag;
    logic checksum_good_flag;
    logic buffer_nonempty_flag;
  } lams_flags_t;

endpackage
